// File: core/dchp_pkg.sv
// Shared constants and types for the diskette controller host port
package dchp_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [31:0] OFF_CMD_STS    = 32'h200B0004;
  localparam logic [31:0] OFF_TRK_ERR    = 32'h200B0006;
  localparam logic [31:0] OFF_SEC_CTRK   = 32'h200B0008;
  localparam logic [31:0] OFF_CSEC_UNIT  = 32'h200B000A;
  localparam logic [31:0] OFF_BAD_CONFIG = 32'h200B000C;
  localparam logic [31:0] OFF_EXT_FN     = 32'h200B000E;
  localparam logic [31:0] OFF_BUF_RD     = 32'h200B0010;
  localparam logic [31:0] OFF_BUF_CLR    = 32'h200B0012;
  localparam logic [31:0] OFF_GO         = 32'h200B0014;
  localparam logic [31:0] OFF_BUF_WR     = 32'h200B0016;

  // ----------------------------------------------------------------
  // Command and status fields
  // ----------------------------------------------------------------
  localparam int unsigned UNIT_LSB  = 1;
  localparam int unsigned UNIT_MSB  = 2;
  localparam int unsigned MOTOR_BIT = 3;
  localparam int unsigned FN_LSB    = 4;
  localparam int unsigned FN_MSB    = 6;
  localparam int unsigned DONE_BIT  = 3;
  localparam int unsigned ERR_BIT   = 7;

  // Function codes
  localparam logic [2:0] FN_READ_STATUS  = 3'h0;
  localparam logic [2:0] FN_SELF_TEST    = 3'h1;
  localparam logic [2:0] FN_RESTORE      = 3'h2;
  localparam logic [2:0] FN_INIT         = 3'h3;
  localparam logic [2:0] FN_READ_SECTOR  = 3'h4;
  localparam logic [2:0] FN_EXTENDED     = 3'h5;
  localparam logic [2:0] FN_READ_ADDR    = 3'h6;
  localparam logic [2:0] FN_WRITE_SECTOR = 3'h7;

  // ----------------------------------------------------------------
  // Geometry, codes, values
  // ----------------------------------------------------------------
  localparam int unsigned BUF_BYTES   = 512;
  localparam int unsigned PTR_W       = 9;
  localparam logic [7:0] TRACK_LIMIT  = 8'h50;
  localparam logic [7:0] SECTOR_MIN   = 8'h01;
  localparam logic [7:0] SECTOR_MAX   = 8'h0A;
  localparam logic [7:0] ERR_NONE     = 8'h00;
  localparam logic [7:0] ERR_TRACK    = 8'h20;
  localparam logic [7:0] ERR_SECTOR   = 8'hB8;
  localparam logic [7:0] IRQ_VECTOR   = 8'hF0;
  localparam logic [7:0] NULL_BYTE    = 8'h00;
  localparam logic [7:0] RESET_BYTE   = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned MOTOR_SHORT_SEC = 3;
  localparam int unsigned MOTOR_LONG_SEC  = 30;
  localparam int unsigned MOTOR_SHORT_CYC = MOTOR_SHORT_SEC * CLK_HZ;
  localparam int unsigned MOTOR_LONG_CYC  = MOTOR_LONG_SEC * CLK_HZ;
  localparam int unsigned MOTOR_CNT_W     = 30;

  typedef enum logic {DCHP_IDLE, DCHP_BUSY} dchp_state_type;

  // Data transfer functions have the top function bit set
  function automatic logic dchp_is_data_fn(input logic [2:0] fn);
    dchp_is_data_fn = fn[2];
  endfunction

endpackage

// File: core/dchp_sector_buffer.sv
// Sector buffer of flip-flops with one write port and two read ports
`timescale 1ns/1ps
`default_nettype none
module dchp_sector_buffer
  import dchp_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    we,
  input  wire logic [dchp_pkg::PTR_W-1:0] widx,
  input  wire logic [7:0]              wdata,
  input  wire logic [dchp_pkg::PTR_W-1:0] ridx_a,
  output logic      [7:0]              rdata_a,
  input  wire logic [dchp_pkg::PTR_W-1:0] ridx_b,
  output logic      [7:0]              rdata_b
);

  logic [7:0] mem_q [BUF_BYTES];
  logic [7:0] mem_d [BUF_BYTES];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Next contents, one byte per write
  always_comb begin
    mem_d = mem_q;
    if (we) begin
      mem_d[widx] = wdata;
    end
  end

  // Data only, so no reset is needed
  always_ff @(posedge clk) begin
    mem_q <= mem_d;
  end

  // Read ports
  assign rdata_a = mem_q[ridx_a];
  assign rdata_b = mem_q[ridx_b];

endmodule
`default_nettype wire

// File: core/dchp_host_port.sv
// Host register port of the diskette controller
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module dchp_host_port
  import dchp_pkg::*;
#(
  parameter int unsigned MOTOR_SHORT_CYCLES = dchp_pkg::MOTOR_SHORT_CYC,
  parameter int unsigned MOTOR_LONG_CYCLES  = dchp_pkg::MOTOR_LONG_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  // Register port
  input  wire logic [31:0]                addr,
  input  wire logic [7:0]                 wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [7:0]                 rdata,
  // Interrupt to the processor
  input  wire logic                       receive_interrupt_enable,
  output logic                            controller_interrupt_request,
  output logic      [7:0]                 irq_vector,
  // Media engine side
  output logic                            eng_start,
  output logic      [2:0]                 eng_function,
  output logic      [1:0]                 eng_unit,
  output logic      [7:0]                 eng_track,
  output logic      [7:0]                 eng_sector,
  output logic      [7:0]                 eng_ext_code,
  output logic                            eng_vol_changed_clear,
  input  wire logic                       eng_done,
  input  wire logic                       eng_error,
  input  wire logic [7:0]                 eng_err_code,
  input  wire logic [7:0]                 eng_cur_track,
  input  wire logic [7:0]                 eng_cur_sector,
  input  wire logic [7:0]                 eng_unit_status,
  input  wire logic [7:0]                 eng_bad_track,
  input  wire logic [7:0]                 eng_config,
  input  wire logic                       eng_buf_we,
  input  wire logic [dchp_pkg::PTR_W-1:0] eng_buf_idx,
  input  wire logic [7:0]                 eng_buf_wdata,
  output logic      [7:0]                 eng_buf_rdata,
  output logic                            spindle_on
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  dchp_state_type         state_q, state_d;
  logic [7:0]             cmd_q, cmd_d;
  logic [7:0]             track_q, track_d;
  logic [7:0]             sector_q, sector_d;
  logic [7:0]             ext_q, ext_d;
  logic [PTR_W-1:0]       ptr_q, ptr_d;
  logic                   sts_err_q, sts_err_d;
  logic [7:0]             sts_cmd_q, sts_cmd_d;
  logic [7:0]             err_code_q, err_code_d;
  logic [7:0]             cs2_q, cs2_d;
  logic [7:0]             cs3_q, cs3_d;
  logic [7:0]             cs4_q, cs4_d;
  logic                   irq_q, irq_d;
  logic                   start_q, start_d;
  logic                   volclr_q, volclr_d;
  logic [7:0]             rdata_q, rdata_d;
  logic                   motor_q, motor_d;
  logic [MOTOR_CNT_W-1:0] mcnt_q, mcnt_d;
  logic                   idle;
  logic                   go;
  logic                   range_bad;
  logic [7:0]             range_code;
  logic                   finish;
  logic                   buf_we;
  logic [PTR_W-1:0]       buf_widx;
  logic [7:0]             buf_wdata;
  logic [7:0]             host_buf_byte;
  logic [7:0]             status_byte;

  assign idle = (state_q == DCHP_IDLE);
  assign go   = rd && (addr == OFF_GO) && idle;

  // ----------------------------------------------------------------
  // Parameter checks before start
  // ----------------------------------------------------------------
  // geometry limits, sector codes
  // Only sector transfers are checked here; other functions go to the
  // engine, which reports its own errors.
  always_comb begin
    range_bad  = 1'b0;
    range_code = ERR_NONE;
    if ((cmd_q[FN_MSB:FN_LSB] == FN_READ_SECTOR) ||
        (cmd_q[FN_MSB:FN_LSB] == FN_WRITE_SECTOR)) begin
      if (track_q >= TRACK_LIMIT) begin
        range_bad  = 1'b1;
        range_code = ERR_TRACK;
      end else if ((sector_q < SECTOR_MIN) ||
                   (sector_q > SECTOR_MAX)) begin
        range_bad  = 1'b1;
        range_code = ERR_SECTOR;
      end
    end
  end

  // Completion: engine finished, or start refused on range
  assign finish = (!idle && eng_done) || (go && range_bad);

  // ----------------------------------------------------------------
  // Command sequencing and status capture
  // ----------------------------------------------------------------
  // write takes the command
  // Writes are dropped while busy so parameters stay stable for the engine.
  always_comb begin
    state_d    = state_q;
    cmd_d      = cmd_q;
    track_d    = track_q;
    sector_d   = sector_q;
    ext_d      = ext_q;
    sts_err_d  = sts_err_q;
    sts_cmd_d  = sts_cmd_q;
    err_code_d = err_code_q;
    cs2_d      = cs2_q;
    cs3_d      = cs3_q;
    cs4_d      = cs4_q;
    start_d    = 1'b0;
    volclr_d   = 1'b0;
    if (wr && idle) begin
      unique case (addr)
        OFF_CMD_STS:  cmd_d = wdata;
        OFF_TRK_ERR:  track_d = wdata;
        OFF_SEC_CTRK: sector_d = wdata;
        OFF_EXT_FN:   ext_d = wdata;
        default: ;
      endcase
    end
    if (go && range_bad) begin
      sts_err_d  = 1'b1;
      sts_cmd_d  = cmd_q;
      err_code_d = range_code;
      cs2_d      = eng_cur_track;
      cs3_d      = eng_cur_sector;
      cs4_d      = eng_bad_track;
    end else if (go) begin
      // engine starts with loaded track and sector
      state_d  = DCHP_BUSY;
      start_d  = 1'b1;
      volclr_d = (cmd_q[FN_MSB:FN_LSB] == FN_READ_STATUS);
    end
    if (!idle && eng_done) begin
      state_d    = DCHP_IDLE;
      // done with error clear on success
      sts_err_d  = eng_error;
      sts_cmd_d  = cmd_q;
      err_code_d = eng_error ? eng_err_code : ERR_NONE;
      cs2_d      = eng_cur_track;
      // non-data functions report through the maintenance view
      if (dchp_is_data_fn(cmd_q[FN_MSB:FN_LSB])) begin
        cs3_d = eng_cur_sector;
        cs4_d = eng_bad_track;
      end else begin
        cs3_d = eng_unit_status;
        cs4_d = eng_config;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= DCHP_IDLE;
      cmd_q      <= RESET_BYTE;
      track_q    <= RESET_BYTE;
      sector_q   <= RESET_BYTE;
      ext_q      <= RESET_BYTE;
      sts_err_q  <= 1'b0;
      sts_cmd_q  <= RESET_BYTE;
      err_code_q <= ERR_NONE;
      cs2_q      <= RESET_BYTE;
      cs3_q      <= RESET_BYTE;
      cs4_q      <= RESET_BYTE;
      start_q    <= 1'b0;
      volclr_q   <= 1'b0;
    end else begin
      state_q    <= state_d;
      cmd_q      <= cmd_d;
      track_q    <= track_d;
      sector_q   <= sector_d;
      ext_q      <= ext_d;
      sts_err_q  <= sts_err_d;
      sts_cmd_q  <= sts_cmd_d;
      err_code_q <= err_code_d;
      cs2_q      <= cs2_d;
      cs3_q      <= cs3_d;
      cs4_q      <= cs4_d;
      start_q    <= start_d;
      volclr_q   <= volclr_d;
    end
  end

  // ----------------------------------------------------------------
  // Buffer pointer
  // ----------------------------------------------------------------
  // one shared pointer
  always_comb begin
    ptr_d = ptr_q;
    if (idle && rd && (addr == OFF_BUF_CLR)) begin
      ptr_d = '0;
    end else if (idle && ((rd && (addr == OFF_BUF_RD)) ||
                          (wr && (addr == OFF_BUF_WR)))) begin
      ptr_d = ptr_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_q <= '0;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  // engine owns the buffer while busy
  assign buf_we    = idle ? (wr && (addr == OFF_BUF_WR)) : eng_buf_we;
  assign buf_widx  = idle ? ptr_q : eng_buf_idx;
  assign buf_wdata = idle ? wdata : eng_buf_wdata;

  dchp_sector_buffer u_buf (
    .clk     (clk),
    .we      (buf_we),
    .widx    (buf_widx),
    .wdata   (buf_wdata),
    .ridx_a  (ptr_q),
    .rdata_a (host_buf_byte),
    .ridx_b  (eng_buf_idx),
    .rdata_b (eng_buf_rdata)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // error in bit 7, done in bit 3
  always_comb begin
    status_byte           = sts_cmd_q;
    status_byte[ERR_BIT]  = sts_err_q;
    status_byte[DONE_BIT] = 1'b1;
  end

  always_comb begin
    rdata_d = NULL_BYTE;
    if (rd && idle) begin
      unique case (addr)
        OFF_CMD_STS:    rdata_d = status_byte;
        OFF_TRK_ERR:    rdata_d = err_code_q;
        OFF_SEC_CTRK:   rdata_d = cs2_q;
        OFF_CSEC_UNIT:  rdata_d = cs3_q;
        OFF_BAD_CONFIG: rdata_d = cs4_q;
        OFF_BUF_RD:     rdata_d = host_buf_byte;
        default:        rdata_d = NULL_BYTE;
      endcase
    end
    // busy reads give a null byte
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= NULL_BYTE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  // raise only when enabled
  // Held until status is read or the next start is read, so a driver that clears its pending
  // flag early sees a second request with done already set.
  always_comb begin
    irq_d = irq_q;
    if (rd && idle && (addr == OFF_CMD_STS)) begin
      irq_d = 1'b0;
    end
    if (go) begin
      irq_d = 1'b0;
    end
    if (finish && receive_interrupt_enable) begin
      irq_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Spindle timeout
  // ----------------------------------------------------------------
  // short or long run-on
  always_comb begin
    motor_d = motor_q;
    mcnt_d  = mcnt_q;
    if (start_q) begin
      motor_d = 1'b1;
      mcnt_d  = '0;
    end else if (!idle && eng_done) begin
      mcnt_d = cmd_q[MOTOR_BIT] ? MOTOR_LONG_CYCLES[MOTOR_CNT_W-1:0]
                                : MOTOR_SHORT_CYCLES[MOTOR_CNT_W-1:0];
    end else if (idle && motor_q && (mcnt_q != '0)) begin
      mcnt_d = mcnt_q - 1'b1;
      if (mcnt_q == {{(MOTOR_CNT_W-1){1'b0}}, 1'b1}) begin
        motor_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      motor_q <= 1'b0;
      mcnt_q  <= '0;
    end else begin
      motor_q <= motor_d;
      mcnt_q  <= mcnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata                       = rdata_q;
  assign controller_interrupt_request = irq_q;
  assign irq_vector                  = IRQ_VECTOR;
  assign eng_start                   = start_q;
  assign eng_function                = cmd_q[FN_MSB:FN_LSB];
  // unit from drive and disk bits
  assign eng_unit                    = cmd_q[UNIT_MSB:UNIT_LSB];
  assign eng_track                   = track_q;
  assign eng_sector                  = sector_q;
  assign eng_ext_code                = ext_q;
  assign eng_vol_changed_clear       = volclr_q;
  assign spindle_on                  = motor_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence seq_go_ok;
    go && !range_bad;
  endsequence

  sequence seq_engine_done;
    !idle && eng_done;
  endsequence

  AST_STATUS_READ: assert property (
    rd && idle && (addr == OFF_CMD_STS) |=>
      rdata[DONE_BIT] && (rdata[ERR_BIT] == sts_err_q))
    else $error("status read lost done or error bit");

  AST_BUSY_NULL: assert property (
    rd && !idle |=> (rdata == NULL_BYTE))
    else $error("busy read did not return null byte");

  AST_PTR_CLEAR: assert property (
    rd && idle && (addr == OFF_BUF_CLR) |=> (ptr_q == '0))
    else $error("pointer not cleared by read");

  AST_PTR_STEP: assert property (
    rd && idle && (addr == OFF_BUF_RD) |=> (ptr_q == $past(ptr_q) + 1'b1))
    else $error("pointer did not step after buffer read");

  AST_GO_START: assert property (
    seq_go_ok |=> eng_start ##1 (!eng_start && !idle || idle))
    else $error("start read did not launch engine");

  AST_IRQ_MASKED: assert property (
    !irq_q && finish && !receive_interrupt_enable |=> !irq_q)
    else $error("interrupt raised while disabled");

  AST_IRQ_RAISE: assert property (
    seq_engine_done ##0 receive_interrupt_enable |=>
      controller_interrupt_request && (irq_vector == 8'hF0))
    else $error("completion interrupt missing or wrong vector");

  AST_SUCCESS: assert property (
    seq_engine_done ##0 !eng_error |=> idle && !sts_err_q
      && (err_code_q == ERR_NONE))
    else $error("success did not clear error status");

  AST_BUSY_WRITE: assert property (
    wr && !idle |=> $stable(track_q) && $stable(cmd_q) && $stable(sector_q))
    else $error("parameter changed by write while busy");

  AST_SPINDLE: assert property (
    seq_engine_done |=> spindle_on [*8])
    else $error("spindle stopped too soon after access");

endmodule
`default_nettype wire

// File: verification/dchp_engine_model.sv
// Behavioural media engine facing the host port
`timescale 1ns/1ps
`default_nettype none
module dchp_engine_model
  import dchp_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       eng_start,
  input  wire logic [2:0]                 eng_function,
  input  wire logic [7:0]                 eng_track,
  output logic                            eng_done,
  output logic                            eng_error,
  output logic      [7:0]                 eng_err_code,
  output logic      [7:0]                 eng_cur_track,
  output logic      [7:0]                 eng_cur_sector,
  output logic      [7:0]                 eng_unit_status,
  output logic      [7:0]                 eng_bad_track,
  output logic      [7:0]                 eng_config,
  output logic                            eng_buf_we,
  output logic      [dchp_pkg::PTR_W-1:0] eng_buf_idx,
  output logic      [7:0]                 eng_buf_wdata
);
  // ----------------------------------------------------------------
  // Status snapshot
  // ----------------------------------------------------------------
  // head ends on the target track
  assign eng_cur_track   = eng_track;
  assign eng_cur_sector  = 8'h07;
  assign eng_unit_status = 8'h11;
  assign eng_bad_track   = 8'h00;
  assign eng_config      = 8'h01;
  assign eng_error       = 1'b0;
  assign eng_err_code    = ERR_NONE;

  // ----------------------------------------------------------------
  // Command service
  // ----------------------------------------------------------------
  initial begin
    eng_done      = 1'b0;
    eng_buf_we    = 1'b0;
    eng_buf_idx   = '0;
    eng_buf_wdata = 8'h00;
  end

  // fill sector in order on a sector read, then finish
  always begin
    @(posedge clk);
    if (eng_start) begin
      if (eng_function == FN_READ_SECTOR) begin
        for (int i = 0; i < BUF_BYTES; i++) begin
          eng_buf_we    <= 1'b1;
          eng_buf_idx   <= i[PTR_W-1:0];
          eng_buf_wdata <= i[7:0] ^ 8'h5A;
          @(posedge clk);
        end
      end
      // Released data goes stale, not held
      eng_buf_we    <= 1'b0;
      eng_buf_wdata <= ~eng_buf_wdata;
      repeat (4) @(posedge clk);
      eng_done <= 1'b1;
      @(posedge clk);
      eng_done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the diskette controller host port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dchp_pkg::*;
  logic        clk, rst_b, wr, rd, rie, irq, e_start, e_done, e_err, e_we;
  logic        spin, e_vc;
  logic [31:0] addr;
  logic [7:0]  wdata, rdata, vec, e_trk, e_sec, e_ext, e_code, e_ctrk;
  logic [7:0]  e_csec, e_ust, e_bad, e_cfg, e_wd, e_rd, d;
  logic [2:0]  e_fn;
  logic [1:0]  e_unit;
  logic [8:0]  e_idx;
  int          err_count, total_checks;

  dchp_host_port #(.MOTOR_SHORT_CYCLES(20), .MOTOR_LONG_CYCLES(40)) u_dut (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .receive_interrupt_enable(rie),
    .controller_interrupt_request(irq), .irq_vector(vec),
    .eng_start(e_start), .eng_function(e_fn), .eng_unit(e_unit),
    .eng_track(e_trk), .eng_sector(e_sec), .eng_ext_code(e_ext),
    .eng_vol_changed_clear(e_vc), .eng_done(e_done), .eng_error(e_err),
    .eng_err_code(e_code), .eng_cur_track(e_ctrk), .eng_cur_sector(e_csec),
    .eng_unit_status(e_ust), .eng_bad_track(e_bad), .eng_config(e_cfg),
    .eng_buf_we(e_we), .eng_buf_idx(e_idx), .eng_buf_wdata(e_wd),
    .eng_buf_rdata(e_rd), .spindle_on(spin));

  dchp_engine_model u_eng (
    .clk(clk), .eng_start(e_start), .eng_function(e_fn), .eng_track(e_trk),
    .eng_done(e_done), .eng_error(e_err), .eng_err_code(e_code),
    .eng_cur_track(e_ctrk), .eng_cur_sector(e_csec),
    .eng_unit_status(e_ust), .eng_bad_track(e_bad), .eng_config(e_cfg),
    .eng_buf_we(e_we), .eng_buf_idx(e_idx), .eng_buf_wdata(e_wd));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wreg(input logic [31:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data is only valid in the cycle after the strobe
  task automatic rreg(input logic [31:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // Bounded wait so a lost completion cannot hang the run
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    check({7'h00, irq}, 8'h01);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rreg(OFF_CMD_STS, d);  check(d, 8'h08);
    rreg(32'h200B0018, d); check(d, 8'h00);
    check(vec, IRQ_VECTOR);
  endtask

  task automatic t_buffer();
    rreg(OFF_BUF_CLR, d);
    wreg(OFF_BUF_WR, 8'hA5);
    wreg(OFF_BUF_WR, 8'h3C);
    rreg(OFF_BUF_CLR, d);
    rreg(OFF_BUF_RD, d); check(d, 8'hA5);
    rreg(OFF_BUF_RD, d); check(d, 8'h3C);
  endtask

  task automatic t_write();
    rreg(OFF_BUF_CLR, d);
    for (int i = 0; i < BUF_BYTES; i++) begin
      wreg(OFF_BUF_WR, i[7:0] ^ 8'hC3);
    end
    // Pointer wrapped back to byte 0 after a full sector
    rreg(OFF_BUF_RD, d); check(d, 8'hC3);
    check(e_rd, 8'hC3);
    wreg(OFF_CMD_STS, 8'h72);
    rie <= 1'b1;
    wreg(OFF_TRK_ERR, 8'h23);
    wreg(OFF_SEC_CTRK, 8'h05);
    wreg(OFF_EXT_FN, 8'h04);
    rreg(OFF_GO, d);
    check({5'h00, e_fn}, 8'h07);
    check({6'h00, e_unit}, 8'h01);
    check(e_trk, 8'h23);
    check(e_sec, 8'h05);
    check(e_ext, 8'h04);
    check({7'h00, e_vc}, 8'h00);
    // Spindle rises one edge after the start pulse
    repeat (2) @(negedge clk);
    check({7'h00, spin}, 8'h01);
    wait_irq();
    rreg(OFF_CMD_STS, d); check(d, 8'h7A);
    @(posedge clk);
    check({7'h00, irq}, 8'h00);
    repeat (30) @(posedge clk);
    check({7'h00, spin}, 8'h00);
  endtask

  task automatic t_status();
    wreg(OFF_CMD_STS, 8'h02);
    rreg(OFF_GO, d);
    check({7'h00, e_vc}, 8'h01);
    wait_irq();
    rreg(OFF_CMD_STS, d);    check(d, 8'h0A);
    rreg(OFF_CSEC_UNIT, d);  check(d, 8'h11);
    rreg(OFF_BAD_CONFIG, d); check(d, 8'h01);
  endtask

  task automatic t_read();
    wreg(OFF_CMD_STS, 8'h48);
    wreg(OFF_TRK_ERR, 8'h1A);
    wreg(OFF_SEC_CTRK, 8'h07);
    rreg(OFF_GO, d);
    rreg(OFF_CMD_STS, d); check(d, NULL_BYTE);
    rreg(OFF_BUF_RD, d);  check(d, NULL_BYTE);
    wait_irq();
    rreg(OFF_CMD_STS, d);  check(d, 8'h48);
    rreg(OFF_SEC_CTRK, d); check(d, 8'h1A);
    rreg(OFF_BUF_CLR, d);
    for (int i = 0; i < 4; i++) begin
      rreg(OFF_BUF_RD, d); check(d, i[7:0] ^ 8'h5A);
    end
    // Long run-on outlasts the short one
    repeat (15) @(posedge clk);
    check({7'h00, spin}, 8'h01);
    repeat (15) @(posedge clk);
    check({7'h00, spin}, 8'h00);
  endtask

  task automatic t_range();
    wreg(OFF_TRK_ERR, TRACK_LIMIT);
    rie <= 1'b0;
    rreg(OFF_GO, d);
    repeat (3) @(posedge clk);
    check({7'h00, irq}, 8'h00);
    rreg(OFF_CMD_STS, d); check(d, 8'hC8);
    rreg(OFF_TRK_ERR, d); check(d, ERR_TRACK);
    // Sector zero is out of range
    wreg(OFF_TRK_ERR, 8'h00);
    wreg(OFF_SEC_CTRK, 8'h00);
    rreg(OFF_GO, d);
    rreg(OFF_TRK_ERR, d); check(d, ERR_SECTOR);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    wr    = 1'b0;
    rd    = 1'b0;
    rie   = 1'b0;
    addr  = 32'h0000_0000;
    wdata = 8'h00;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_buffer();
    t_write();
    t_status();
    t_read();
    t_range();
    stop_test();
  end

  initial begin
    #(50 * 20000);
    err_count++;
    stop_test();
  end
endmodule
`default_nettype wire
